// ---- hdl/vsf_pkg.sv ----
package vsf_pkg;
  localparam int DATA_W = 10;
  localparam int COEF_W = 12;
  localparam int HWORD_W = 344;
  localparam int VWORD_W = 432;
  localparam int WIN_W = 12;
  localparam int LIVE_W = 13;
  localparam int NPATH = 4;
  localparam int NFIELD = 11;
  // Path order: horizontal luma, horizontal chroma, vertical luma, vertical chroma
  localparam int TAPS_NORM[NPATH] = '{21, 13, 21, 21};
  localparam int TAPS_DEC[NPATH] = '{41, 25, 41, 41};
  localparam int PHASES[NPATH] = '{128, 64, 128, 128};
  localparam int PHASE_BITS[NPATH] = '{7, 6, 7, 7};
  localparam int BANK0_MSB[NPATH] = '{236, 64, 324, 110};
  localparam int BANK1_MSB[NPATH] = '{343, 129, 431, 217};
  localparam int FIELD_W_Y[NFIELD] = '{12, 12, 11, 10, 10, 9, 9, 9, 9, 8, 8};
  localparam int FIELD_W_HC[NFIELD] = '{12, 11, 9, 9, 8, 8, 8, 0, 0, 0, 0};
  localparam int GAIN_SHIFT = 10;
  localparam int DC_GAIN = 1024;
  localparam int ACC_FRAC = 19;
  localparam int ACC_W = 22;
  localparam logic [ACC_W-1:0] ACC_ONE = 22'h080000;
  localparam logic [ACC_W-1:0] ACC_RESET = 22'h000000;
  localparam logic [DATA_W-1:0] DATA_MAX = 10'h3FF;
  localparam int FIFO_DEPTH = 8;
  typedef logic signed [COEF_W-1:0] vsf_coef_t;
  typedef vsf_coef_t vsf_bank_t [NFIELD];
endpackage : vsf_pkg

// ---- hdl/vsf_scaler.sv ----
`timescale 1ns/1ns
`default_nettype none

module vsf_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign inReady = (cnt_reg != (AW+1)'(DEPTH));
  assign outValid = (cnt_reg != '0);
  assign outData = mem_reg[rd_reg];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wr_next = push ? ((wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next = pop ? ((rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= inData;
    end
  end
endmodule : vsf_fifo

module vsf_scaler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [vsf_pkg::NPATH-1:0] sampleValid,
  output logic [vsf_pkg::NPATH-1:0] sampleReady,
  input wire logic [vsf_pkg::NPATH-1:0][vsf_pkg::DATA_W-1:0] sampleData,
  output logic [vsf_pkg::NPATH-1:0] resultValid,
  input wire logic [vsf_pkg::NPATH-1:0] resultReady,
  output logic [vsf_pkg::NPATH-1:0][vsf_pkg::DATA_W-1:0] resultData,
  input wire logic hLineStart,
  input wire logic vLineStart,
  input wire logic [vsf_pkg::ACC_W-1:0] hZoomRatio,
  input wire logic [vsf_pkg::ACC_W-1:0] vZoomRatio,
  input wire logic [vsf_pkg::ACC_W-1:0] hStartPhase,
  input wire logic [vsf_pkg::ACC_W-1:0] vStartPhase,
  input wire logic horizDecimateSelect,
  input wire logic vertDecimateSelect,
  input wire logic [vsf_pkg::HWORD_W-1:0] horizontalCoefficientWord,
  input wire logic horizontalCoefficientLoad,
  input wire logic [vsf_pkg::VWORD_W-1:0] verticalCoefficientWord,
  input wire logic verticalCoefficientLoad,
  input wire logic frameBoundary,
  input wire logic interlaced,
  input wire logic filmMode,
  input wire logic fieldHasExtraLine,
  input wire logic [vsf_pkg::WIN_W-1:0] inputWindowLeft,
  input wire logic [vsf_pkg::WIN_W-1:0] inputWindowRight,
  input wire logic [vsf_pkg::WIN_W-1:0] inputWindowTop,
  input wire logic [vsf_pkg::WIN_W-1:0] inputWindowBottom,
  input wire logic [vsf_pkg::WIN_W-1:0] outputWindowLeft,
  input wire logic [vsf_pkg::WIN_W-1:0] outputWindowRight,
  input wire logic [vsf_pkg::WIN_W-1:0] outputWindowTop,
  input wire logic [vsf_pkg::WIN_W-1:0] outputWindowBottom,
  output logic [vsf_pkg::LIVE_W-1:0] inputLiveWidth,
  output logic [vsf_pkg::LIVE_W-1:0] inputLiveHeight,
  output logic [vsf_pkg::LIVE_W-1:0] outputLiveWidth,
  output logic [vsf_pkg::LIVE_W-1:0] outputLiveHeight
);
  import vsf_pkg::*;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Signed field with sign extension to the coefficient width
  function automatic vsf_coef_t fieldAt(input logic [VWORD_W-1:0] w, input int lsb,
                                        input int wd);
    vsf_coef_t f;
    f = '0;
    for (int b = 0; b < COEF_W; b++) begin
      f[b] = (b < wd) ? w[lsb + b] : w[lsb + wd - 1];
    end
    return f;
  endfunction : fieldAt

  // Fields packed from the bank's top bit downward
  function automatic vsf_bank_t unpackBank(input logic [VWORD_W-1:0] w, input int msb,
                                           input bit hChroma);
    vsf_bank_t bank;
    int top, wd;
    top = msb;
    for (int i = 0; i < NFIELD; i++) begin
      wd = hChroma ? FIELD_W_HC[i] : FIELD_W_Y[i];
      bank[i] = (wd > 0) ? fieldAt(w, top - wd + 1, wd) : '0;
      top = top - wd;
    end
    return bank;
  endfunction : unpackBank

  function automatic logic [LIVE_W-1:0] liveSize(input logic [WIN_W-1:0] first,
                                                 input logic [WIN_W-1:0] last);
    return LIVE_W'(last) - LIVE_W'(first) + 1'b1;
  endfunction : liveSize

  function automatic logic [LIVE_W-1:0] liveHeight(input logic [WIN_W-1:0] top,
                                                   input logic [WIN_W-1:0] bottom,
                                                   input logic il, input logic film,
                                                   input logic extra);
    logic [LIVE_W-1:0] field;
    field = liveSize(top, bottom);
    if (il && film) begin
      return LIVE_W'({field, 1'b0}) + LIVE_W'(extra);
    end
    return field + LIVE_W'(il && extra);
  endfunction : liveHeight
  // Window sizes
  logic [LIVE_W-1:0] inW_reg, inW_next, inH_reg, inH_next;
  logic [LIVE_W-1:0] outW_reg, outW_next, outH_reg, outH_next;
  always_comb begin
    inW_next = liveSize(inputWindowLeft, inputWindowRight);
    inH_next = liveHeight(inputWindowTop, inputWindowBottom, interlaced, filmMode,
                          fieldHasExtraLine);
    outW_next = liveSize(outputWindowLeft, outputWindowRight);
    outH_next = liveHeight(outputWindowTop, outputWindowBottom, interlaced, filmMode,
                           fieldHasExtraLine);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inW_reg <= '0;
      inH_reg <= '0;
      outW_reg <= '0;
      outH_reg <= '0;
    end else begin
      inW_reg <= inW_next;
      inH_reg <= inH_next;
      outW_reg <= outW_next;
      outH_reg <= outH_next;
    end
  end
  assign inputLiveWidth = inW_reg;
  assign inputLiveHeight = inH_reg;
  assign outputLiveWidth = outW_reg;
  assign outputLiveHeight = outH_reg;
  live_width_a: assert property (
    $past(rst_n) |->
      inputLiveWidth == $past(LIVE_W'(inputWindowRight) - LIVE_W'(inputWindowLeft) + 1'b1))
    else $error("input live width wrong");
  extra_line_a: assert property (
    (interlaced && !filmMode && fieldHasExtraLine) |=>
      (inputLiveHeight == liveSize($past(inputWindowTop), $past(inputWindowBottom)) + 1'b1))
    else $error("longer field height wrong");
  // Coefficients pending on download, decimate modes sampled directly; both active at frame boundary
  logic [HWORD_W-1:0] hPend_reg, hPend_next, hAct_reg, hAct_next;
  logic [VWORD_W-1:0] vPend_reg, vPend_next, vAct_reg, vAct_next;
  logic hDec_reg, hDec_next, vDec_reg, vDec_next;
  always_comb begin
    hPend_next = horizontalCoefficientLoad ? horizontalCoefficientWord : hPend_reg;
    vPend_next = verticalCoefficientLoad ? verticalCoefficientWord : vPend_reg;
    hAct_next = frameBoundary ? hPend_reg : hAct_reg;
    vAct_next = frameBoundary ? vPend_reg : vAct_reg;
    hDec_next = frameBoundary ? horizDecimateSelect : hDec_reg;
    vDec_next = frameBoundary ? vertDecimateSelect : vDec_reg;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hPend_reg <= '0;
      vPend_reg <= '0;
      hAct_reg <= '0;
      vAct_reg <= '0;
      hDec_reg <= 1'b0;
      vDec_reg <= 1'b0;
    end else begin
      hPend_reg <= hPend_next;
      vPend_reg <= vPend_next;
      hAct_reg <= hAct_next;
      vAct_reg <= vAct_next;
      hDec_reg <= hDec_next;
      vDec_reg <= vDec_next;
    end
  end
  coef_swap_a: assert property (
    !frameBoundary |=> $stable(hAct_reg) && $stable(vAct_reg) && $stable(hDec_reg))
    else $error("coefficients changed mid field");
  for (genvar p = 0; p < NPATH; p++) begin : g_path
    localparam bit HORIZ = (p < 2);
    localparam bit HCHROMA = (p == 1);
    localparam int NF = (TAPS_NORM[p] - 1) / 2;
    localparam int HALF = (TAPS_DEC[p] - 1) / 2;
    localparam int NTAP = TAPS_DEC[p];
    localparam int PB = PHASE_BITS[p];
    localparam logic [PB:0] NPH = (PB+1)'(PHASES[p]);
    logic [VWORD_W-1:0] word;
    vsf_bank_t bank0, bank1;
    logic dec, lineStart, accept, fire, emit, fifoReady;
    logic [ACC_W-1:0] ratio, startPh;
    logic signed [31:0] firAcc, firRound;
    logic [DATA_W-1:0] firSample, interpOut;
    logic [PB-1:0] phase;
    logic [DATA_W+PB+1:0] interpSum;
    logic [DATA_W-1:0] tap_reg [NTAP];
    logic [DATA_W-1:0] tap_next [NTAP];
    logic decPh_reg, decPh_next;
    logic [1:0] fill_reg, fill_next;
    logic [DATA_W-1:0] a_reg, a_next, b_reg, b_next;
    logic [ACC_W-1:0] acc_reg, acc_next;
    assign word = HORIZ ? VWORD_W'(hAct_reg) : vAct_reg;
    assign bank0 = unpackBank(word, BANK0_MSB[p], HCHROMA);
    assign bank1 = unpackBank(word, BANK1_MSB[p], HCHROMA);
    assign dec = HORIZ ? hDec_reg : vDec_reg;
    assign lineStart = HORIZ ? hLineStart : vLineStart;
    assign ratio = HORIZ ? hZoomRatio : vZoomRatio;
    assign startPh = HORIZ ? hStartPhase : vStartPhase;
    // Symmetric FIR; weight chosen by distance and mode
    always_comb begin
      vsf_coef_t wt;
      logic signed [31:0] pair;
      wt = '0;
      pair = '0;
      firAcc = 32'(bank0[0]) * 32'($signed({1'b0, tap_reg[HALF]}));
      for (int d = 1; d <= HALF; d++) begin
        if (dec) begin
          wt = (d % 2 == 1) ? bank0[(d + 1) / 2] : bank1[d / 2];
        end else begin
          wt = (d <= NF) ? bank0[d] : '0;
        end
        pair = 32'($signed({1'b0, tap_reg[HALF - d]})) +
               32'($signed({1'b0, tap_reg[HALF + d]}));
        firAcc = firAcc + 32'(wt) * pair;
      end
      firRound = (firAcc + 32'sd512) >>> GAIN_SHIFT;
      if (firRound < 0) begin
        firSample = '0;
      end else if (firRound > 32'($signed({1'b0, DATA_MAX}))) begin
        firSample = DATA_MAX;
      end else begin
        firSample = firRound[DATA_W-1:0];
      end
    end
    // Two-point polyphase interpolation at the selected phase
    always_comb begin
      phase = acc_reg[ACC_FRAC-1 -: PB];
      interpSum = (DATA_W+PB+2)'(a_reg * (NPH - (PB+1)'(phase))) +
                  (DATA_W+PB+2)'(b_reg * phase) + (DATA_W+PB+2)'(NPH >> 1);
      interpOut = interpSum[PB +: DATA_W];
    end
    assign sampleReady[p] = (fill_reg < 2'd2) || (acc_reg >= ACC_ONE);
    assign accept = sampleValid[p] && sampleReady[p] && !lineStart;
    assign fire = accept && (!dec || decPh_reg);
    assign emit = (fill_reg == 2'd2) && (acc_reg < ACC_ONE) && fifoReady && !lineStart;

    always_comb begin
      tap_next = tap_reg;
      decPh_next = decPh_reg;
      fill_next = fill_reg;
      a_next = a_reg;
      b_next = b_reg;
      acc_next = acc_reg;
      if (lineStart) begin
        decPh_next = 1'b0;
        fill_next = '0;
        acc_next = startPh;
      end else begin
        if (accept) begin
          for (int i = 0; i < NTAP - 1; i++) begin
            tap_next[i] = tap_reg[i + 1];
          end
          tap_next[NTAP-1] = sampleData[p];
          decPh_next = dec ? !decPh_reg : 1'b0;
        end
        if (fire) begin
          a_next = b_reg;
          b_next = firSample;
          if (fill_reg == 2'd2) begin
            acc_next = acc_reg - ACC_ONE;
          end else begin
            fill_next = fill_reg + 1'b1;
          end
        end
        if (emit) begin
          acc_next = acc_reg + ratio;
        end
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tap_reg <= '{default: '0};
        decPh_reg <= 1'b0;
        fill_reg <= '0;
        a_reg <= '0;
        b_reg <= '0;
        acc_reg <= ACC_RESET;
      end else begin
        tap_reg <= tap_next;
        decPh_reg <= decPh_next;
        fill_reg <= fill_next;
        a_reg <= a_next;
        b_reg <= b_next;
        acc_reg <= acc_next;
      end
    end
    vsf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .inValid(emit),
      .inReady(fifoReady),
      .inData(interpOut),
      .outValid(resultValid[p]),
      .outReady(resultReady[p]),
      .outData(resultData[p])
    );
    sequence decFirst;
      accept && dec && !decPh_reg;
    endsequence
    sequence decSecondArmed;
      decPh_reg && (!accept || fire);
    endsequence
    dec_rate_a: assert property (
      decFirst |-> !fire)
      else $error("decimate fired on first of pair");
    dec_second_a: assert property (
      decFirst |=> decSecondArmed)
      else $error("decimate pairing broken");
    round_clip_a: assert property (
      fire && (firAcc > 32'sd1048064) |=> (b_reg == DATA_MAX))
      else $error("result not clipped");
    start_phase_a: assert property (
      lineStart |=> (acc_reg == $past(startPh)) && (fill_reg == 2'd0))
      else $error("start phase not loaded");
    acc_step_a: assert property (
      emit |=> (acc_reg == $past(acc_reg) + $past(ratio)))
      else $error("phase step wrong");
    hold_input_a: assert property (
      (fill_reg == 2'd2 && acc_reg < ACC_ONE) |-> !sampleReady[p])
      else $error("input taken while outputs pending");
    discard_a: assert property (
      (fill_reg == 2'd2 && acc_reg >= ACC_ONE) |-> !emit)
      else $error("surplus output emitted");
    phase_sel_a: assert property (
      emit |-> (phase == acc_reg[ACC_FRAC-1 -: PB]) && (acc_reg[ACC_W-1:ACC_FRAC] == '0))
      else $error("phase outside interval");
  end
endmodule : vsf_scaler

`default_nettype wire

// ---- sim/vsf_scaler_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none

module vsf_scaler_tb_top;
  import vsf_pkg::*;
  localparam int LINE = 256;
  localparam int CEILING = 20000;
  logic clk, rst_n, hLineStart, vLineStart, horizDec, vertDec, hLoad, vLoad;
  logic frameBoundary, interlaced, filmMode, extraLine, start, stallEn;
  logic [NPATH-1:0] sampleValid, sampleReady, resultValid, resultReady;
  logic [NPATH-1:0][DATA_W-1:0] sampleData, resultData;
  logic [NPATH-1:0][15:0] accCount, popCount, badCount;
  logic [ACC_W-1:0] zoomRatio, startPhase;
  logic [HWORD_W-1:0] hWord;
  logic [VWORD_W-1:0] vWord;
  logic [WIN_W-1:0] win [8];
  logic [LIVE_W-1:0] inW, inH, outW, outH;
  logic [DATA_W-1:0] pValue, pExpect;
  int nErrors, checksDone, cycles, holdCount;

  vsf_scaler i_vsf_scaler (.clk(clk), .rst_n(rst_n), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleData(sampleData), .resultValid(resultValid),
    .resultReady(resultReady), .resultData(resultData), .hLineStart(hLineStart),
    .vLineStart(vLineStart), .hZoomRatio(zoomRatio), .vZoomRatio(zoomRatio),
    .hStartPhase(startPhase), .vStartPhase(startPhase), .horizDecimateSelect(horizDec),
    .vertDecimateSelect(vertDec), .horizontalCoefficientWord(hWord),
    .horizontalCoefficientLoad(hLoad), .verticalCoefficientWord(vWord),
    .verticalCoefficientLoad(vLoad), .frameBoundary(frameBoundary),
    .interlaced(interlaced), .filmMode(filmMode), .fieldHasExtraLine(extraLine),
    .inputWindowLeft(win[0]), .inputWindowRight(win[1]), .inputWindowTop(win[2]),
    .inputWindowBottom(win[3]), .outputWindowLeft(win[4]), .outputWindowRight(win[5]),
    .outputWindowTop(win[6]), .outputWindowBottom(win[7]), .inputLiveWidth(inW),
    .inputLiveHeight(inH), .outputLiveWidth(outW), .outputLiveHeight(outH));

  vsf_stream_partner i_vsf_stream_partner (.clk(clk), .rst_n(rst_n), .start(start),
    .lineLen(16'(LINE)), .value(pValue), .expectValue(pExpect), .stallEn(stallEn),
    .sampleValid(sampleValid), .sampleReady(sampleReady), .sampleData(sampleData),
    .resultValid(resultValid), .resultReady(resultReady), .resultData(resultData),
    .accCount(accCount), .popCount(popCount), .badCount(badCount));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (|(sampleValid & ~sampleReady)) holdCount <= holdCount + 1;
    if (cycles == CEILING) begin
      nErrors++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expected);
    checksDone++;
    if (seen !== expected) begin
      nErrors++;
      $display("mismatch %s expected %0h seen %0h", what, expected, seen);
    end
  endtask : check

  task tally_and_finish();
    if (nErrors == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  function automatic void putField(inout logic [VWORD_W-1:0] w, input int msb,
                                   input int width, input int value);
    for (int k = 0; k < width; k++) w[msb - width + 1 + k] = value[k];
  endfunction : putField

  // Centre c0, first odd tap c1, first even tap c2 on every path; all else zero
  task automatic loadSet(input int c0, input int c1, input int c2, input logic dec,
                         input bit boundary);
    logic [VWORD_W-1:0] wd [2];
    int w;
    wd[0] = '0;
    wd[1] = '0;
    for (int p = 0; p < NPATH; p++) begin
      w = (p == 1) ? 11 : 12;
      putField(wd[p / 2], BANK0_MSB[p], 12, c0);
      putField(wd[p / 2], BANK0_MSB[p] - 12, w, c1);
      putField(wd[p / 2], BANK1_MSB[p] - 12, w, c2);
    end
    @(posedge clk);
    hWord <= wd[0][HWORD_W-1:0];
    vWord <= wd[1];
    hLoad <= 1'b1;
    vLoad <= 1'b1;
    horizDec <= dec;
    vertDec <= dec;
    @(posedge clk);
    hLoad <= 1'b0;
    vLoad <= 1'b0;
    frameBoundary <= boundary;
    @(posedge clk);
    frameBoundary <= 1'b0;
  endtask : loadSet

  task automatic runLine(input logic [ACC_W-1:0] ratio, input logic [DATA_W-1:0] val,
                         input logic [DATA_W-1:0] expv, input int num, input int den);
    int mid;
    int holdStart;
    mid = LINE * num / den;
    @(posedge clk);
    zoomRatio <= ratio;
    pValue <= val;
    pExpect <= expv;
    hLineStart <= 1'b1;
    vLineStart <= 1'b1;
    @(posedge clk);
    hLineStart <= 1'b0;
    vLineStart <= 1'b0;
    start <= 1'b1;
    holdStart = holdCount;
    @(posedge clk);
    start <= 1'b0;
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (accCount === {NPATH{16'(LINE)}} && resultValid === '0) break;
    end
    repeat (16) @(posedge clk);
    #1;
    for (int p = 0; p < NPATH; p++) begin
      check("wrong outputs", badCount[p], 32'h00000000);
      check("output count", 32'(popCount[p] >= mid - 12 && popCount[p] <= mid + 2),
            32'h00000001);
    end
    if (num > den) check("input held", 32'(holdCount > holdStart), 32'h00000001);
  endtask : runLine

  function automatic int expHeight(int top, int bottom, bit il, bit film, bit extra);
    if (il && film) return 2 * (bottom - top + 1) + int'(extra);
    if (il) return bottom - top + 1 + int'(extra);
    return bottom - top + 1;
  endfunction : expHeight

  int topV[4] = '{5, 5, 5, 0};
  int botV[4] = '{244, 244, 244, 1079};
  bit ilV[4] = '{0, 1, 1, 0};
  bit filmV[4] = '{0, 0, 1, 1};
  bit extraV[4] = '{0, 1, 1, 1};

  initial begin
    {rst_n, hLineStart, vLineStart, horizDec, vertDec, hLoad, vLoad} = '0;
    {frameBoundary, interlaced, filmMode, extraLine, start} = '0;
    stallEn = 1'b1;
    zoomRatio = ACC_ONE;
    startPhase = ACC_RESET;
    hWord = '0;
    vWord = '0;
    pValue = '0;
    pExpect = '0;
    for (int i = 0; i < 8; i++) win[i] = '0;
    {nErrors, checksDone, cycles, holdCount} = '0;
    repeat (10) @(posedge clk);
    #1;
    check("valid in reset", resultValid, 32'h00000000);
    check("ready in reset", sampleReady, 32'h0000000F);
    check("size in reset", {inW, inH}, 32'h00000000);
    @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      win[0] <= 12'(3 * i);
      win[1] <= 12'(729 + i);
      win[2] <= 12'(topV[i]);
      win[3] <= 12'(botV[i]);
      win[4] <= 12'h000;
      win[5] <= 12'h77F;
      win[6] <= 12'(topV[i] + 1);
      win[7] <= 12'(botV[i] + 2);
      interlaced <= ilV[i];
      filmMode <= filmV[i];
      extraLine <= extraV[i];
      repeat (2) @(posedge clk);
      #1;
      check("input width", inW, 32'((729 + i) - 3 * i + 1));
      check("input height", inH, 32'(expHeight(topV[i], botV[i], ilV[i], filmV[i],
            extraV[i])));
      check("output width", outW, 32'h00000780);
      check("output height", outH, 32'(expHeight(topV[i] + 1, botV[i] + 2, ilV[i],
            filmV[i], extraV[i])));
    end
    loadSet(512, 256, 0, 1'b0, 1'b0);
    runLine(ACC_ONE, 10'h1F4, 10'h000, 1, 1);
    loadSet(512, 256, 0, 1'b0, 1'b1);
    runLine(ACC_ONE, 10'h1F4, 10'h1F4, 1, 1);
    runLine(22'h040000, 10'h1F4, 10'h1F4, 2, 1);
    runLine(22'h100000, 10'h1F4, 10'h1F4, 1, 2);
    loadSet(512, 128, 128, 1'b1, 1'b1);
    runLine(ACC_ONE, 10'h1F4, 10'h1F4, 1, 2);
    loadSet(1023, 0, 0, 1'b0, 1'b1);
    runLine(ACC_ONE, 10'h1F4, 10'h1F4, 1, 1);
    loadSet(2047, 0, 0, 1'b0, 1'b1);
    runLine(ACC_ONE, 10'h2BC, 10'h3FF, 1, 1);
    loadSet(1536, -256, 0, 1'b0, 1'b1);
    runLine(ACC_ONE, 10'h1F4, 10'h1F4, 1, 1);
    tally_and_finish();
  end
endmodule : vsf_scaler_tb_top

`default_nettype wire

// ---- sim/vsf_stream_partner.sv ----
`timescale 1ns/1ns
`default_nettype none

module vsf_stream_partner (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [15:0] lineLen,
  input wire logic [vsf_pkg::DATA_W-1:0] value,
  input wire logic [vsf_pkg::DATA_W-1:0] expectValue,
  input wire logic stallEn,
  output logic [vsf_pkg::NPATH-1:0] sampleValid,
  input wire logic [vsf_pkg::NPATH-1:0] sampleReady,
  output logic [vsf_pkg::NPATH-1:0][vsf_pkg::DATA_W-1:0] sampleData,
  input wire logic [vsf_pkg::NPATH-1:0] resultValid,
  output logic [vsf_pkg::NPATH-1:0] resultReady,
  input wire logic [vsf_pkg::NPATH-1:0][vsf_pkg::DATA_W-1:0] resultData,
  output logic [vsf_pkg::NPATH-1:0][15:0] accCount,
  output logic [vsf_pkg::NPATH-1:0][15:0] popCount,
  output logic [vsf_pkg::NPATH-1:0][15:0] badCount
);
  import vsf_pkg::*;
  // Early outputs see taps from before the line
  localparam int SKIP = 64;
  logic [1:0] stallPhase;
  logic sending;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stallPhase <= 2'h0;
      sending <= 1'b0;
      accCount <= '0;
      popCount <= '0;
      badCount <= '0;
    end else begin
      stallPhase <= stallPhase + 2'h1;
      if (start) begin
        sending <= 1'b1;
      end
      for (int p = 0; p < NPATH; p++) begin
        if (start) begin
          accCount[p] <= 16'h0000;
          popCount[p] <= 16'h0000;
          badCount[p] <= 16'h0000;
        end else begin
          if (sampleValid[p] && sampleReady[p]) begin
            accCount[p] <= accCount[p] + 16'h0001;
          end
          if (resultValid[p] && resultReady[p]) begin
            popCount[p] <= popCount[p] + 16'h0001;
            if (popCount[p] >= SKIP && resultData[p] !== expectValue) begin
              badCount[p] <= badCount[p] + 16'h0001;
            end
          end
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < NPATH; p++) begin
      sampleValid[p] = sending && (accCount[p] < lineLen);
      // Idle data lines show the inverse, never a stale copy
      sampleData[p] = sampleValid[p] ? value : ~value;
      resultReady[p] = !(stallEn && stallPhase == 2'h0);
    end
  end
endmodule : vsf_stream_partner

`default_nettype wire
